/* File: rtl/msau_top.sv */
// memory space access unit: program fetch sequencing and data space access
// assumes the cpu pipeline drives read/write requests for one cycle each
//
// What this block does
// - program location is even lower word plus odd upper word, top byte unused
// - program counter stays even and steps by two per word
// - program addresses below 000200h are vector space, not user code
// - fetching starts at 000000h; image puts jump there, target at 000002h
// - primary vectors at 000004h-0000FFh, alternate at 000100h-0001FFh
// - top four program words copied into configuration registers on reset
// - configuration bits are remapped between flash and register order
// - sixteen-bit effective addresses select bytes in a 64 Kbyte space
// - address bit 15 clear goes to memory, set goes to visibility window
// - 16 Kbytes implemented; reads outside return zero
// - separate address generators for reads and for writes
// - low byte at even address, high byte at odd address
// - post-increment adds one for bytes, two for words
// - byte read picks a byte by bit 0 onto the low lane
// - byte write strobes only the lane of the addressed byte
// - word access at odd address raises address error trap
// - misaligned write is suppressed, instruction completes, then trap
// - byte load into working register keeps the high byte
// - sign widen and zero widen operations on a working register byte
// - memory direct uses thirteen-bit field reaching 0000h-1FFFh
// - higher addresses only indirect, except moves with sixteen-bit field
// - user program access confined below 800000h except table config access
// - lowest 2 Kbytes hold function registers; unimplemented ones read zero
`timescale 1ns/1ps
module msau_top #(
  parameter logic [23:0] CFG_BASE = msau_pkg::CFG_BASE_LARGE,
  parameter logic [23:0] PROG_TOP = msau_pkg::CFG_BASE_LARGE + 24'h000007
) (
  input wire logic clk,
  input wire logic rst_b,
  // program counter control
  input wire logic pcAdvance,
  input wire logic pcBackward,
  input wire logic pcLoad,
  input wire logic [23:0] pcLoadValue,
  input wire logic vectorTake,
  input wire logic vectorAlternate,
  input wire logic [6:0] vectorIndex,
  output logic [23:0] programCounter_reg,
  output logic programFetchValid,
  // program memory port
  input wire logic [23:0] progWordData,
  output logic [23:0] progAddr,
  output logic [23:0] fetchWord_reg,
  output logic progUnimplemented,
  // table access
  input wire logic tableRead,
  input wire logic [7:0] tablePageRegister,
  input wire logic [15:0] tableOffset,
  output logic tableAccessDenied,
  // data read and write requests
  input wire msau_pkg::msau_req_t readReq,
  input wire msau_pkg::msau_req_t writeReq,
  input wire logic [15:0] writeData,
  output logic [15:0] readPointerNext,
  output logic [15:0] writePointerNext,
  // data memory / function register array
  input wire logic [15:0] memReadWord,
  input wire logic sfrImplemented,
  output logic [14:0] memReadWordAddr,
  output logic [14:0] memWriteWordAddr,
  output logic [1:0] memWriteLane,
  output logic [15:0] memWriteData,
  output logic psvRead,
  output logic [15:0] readData_reg,
  // working register byte handling
  input wire logic [15:0] workingRegOld,
  input wire msau_pkg::msau_widen_t widenOp,
  output logic [15:0] workingRegNew,
  // trap and configuration
  output logic addressErrorTrap_reg,
  output logic [63:0] configRegs,
  output logic configReady
);
  logic [15:0] readAddress;
  logic [15:0] writeAddress;
  logic readMisaligned;
  logic writeMisaligned;
  logic readPsv;
  logic writePsv;
  logic readOutside;
  logic cfgReadReq;
  logic [23:0] cfgReadAddr;
  logic [15:0] rawByte;

  // ------------------------------------------------------------
  // address generators
  // ------------------------------------------------------------
  msau_addr_gen readGen (
    .clk(clk), .rst_b(rst_b), .req(readReq),
    .effectiveByteAddress(readAddress), .pointerNext(readPointerNext),
    .misaligned(readMisaligned), .psvSelect(readPsv), .lastAddress_reg()
  );
  msau_addr_gen writeGen (
    .clk(clk), .rst_b(rst_b), .req(writeReq),
    .effectiveByteAddress(writeAddress), .pointerNext(writePointerNext),
    .misaligned(writeMisaligned), .psvSelect(writePsv), .lastAddress_reg()
  );

  // ------------------------------------------------------------
  // configuration copy
  // ------------------------------------------------------------
  msau_cfg_loader #(.CFG_BASE(CFG_BASE)) cfgLoader (
    .clk(clk), .rst_b(rst_b), .progReadData(progWordData[15:0]),
    .cfgReadReq(cfgReadReq), .cfgReadAddr(cfgReadAddr),
    .cfgRegs_reg(configRegs), .cfgDone(configReady)
  );

  // ------------------------------------------------------------
  // program counter
  // ------------------------------------------------------------
  // no fetch until configuration is loaded; shares the program port
  assign programFetchValid = configReady;
  assign progAddr = cfgReadReq ? cfgReadAddr : {programCounter_reg[23:1], 1'b0};

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      programCounter_reg <= msau_pkg::PROG_RESET_ADDR;
    end else if (configReady) begin
      if (vectorTake) begin
        // one handler word per source, base picks primary or alternate table
        programCounter_reg <= (vectorAlternate ? msau_pkg::IVT_ALT_LO : msau_pkg::IVT_PRI_LO)
          + {16'h0, vectorIndex, 1'b0};
      end else if (pcLoad) begin
        programCounter_reg <= {pcLoadValue[23:1], 1'b0};
      end else if (pcAdvance) begin
        programCounter_reg <= pcBackward ? programCounter_reg - msau_pkg::PC_STEP
          : programCounter_reg + msau_pkg::PC_STEP;
      end
    end
  end

  // addresses above PROG_TOP are unimplemented; fetches there load zero
  assign progUnimplemented = (progAddr > PROG_TOP) && !cfgReadReq;
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      fetchWord_reg <= 24'h000000;
    end else if (configReady) begin
      fetchWord_reg <= progUnimplemented ? 24'h000000 : progWordData;
    end
  end

  // table reads reach config space only with the page bit set
  assign tableAccessDenied = tableRead && !tablePageRegister[msau_pkg::TBL_PAGE_CFG_BIT]
    && ({tablePageRegister, tableOffset} > msau_pkg::USER_SPACE_HI);

  // ------------------------------------------------------------
  // data read path
  // ------------------------------------------------------------
  assign memReadWordAddr = readAddress[15:1];
  assign psvRead = readReq.valid && readPsv;
  assign readOutside = readPsv || (readAddress > msau_pkg::DATA_IMPL_TOP)
    || ((readAddress <= msau_pkg::SFR_TOP) && !sfrImplemented);
  assign rawByte = readAddress[0] ? {8'h00, memReadWord[15:8]}
    : {8'h00, memReadWord[7:0]};

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      readData_reg <= 16'h0000;
    end else if (readReq.valid && !readPsv) begin
      if (readOutside) begin
        readData_reg <= 16'h0000;
      end else begin
        readData_reg <= readReq.isByte ? rawByte : memReadWord;
      end
    end
  end

  // ------------------------------------------------------------
  // data write path
  // ------------------------------------------------------------
  assign memWriteWordAddr = writeAddress[15:1];
  assign memWriteData = writeReq.isByte ? {writeData[7:0], writeData[7:0]} : writeData;

  // faulting or out-of-range writes never raise a lane
  always_comb begin
    memWriteLane = 2'h0;
    if (writeReq.valid && !writeMisaligned && !writePsv
        && writeAddress <= msau_pkg::DATA_IMPL_TOP) begin
      if (writeReq.isByte) begin
        memWriteLane = writeAddress[0] ? 2'h2 : 2'h1;
      end else begin
        memWriteLane = 2'h3;
      end
    end
  end

  // trap pulses the cycle after the instruction's access
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      addressErrorTrap_reg <= 1'b0;
    end else begin
      addressErrorTrap_reg <= readMisaligned || writeMisaligned;
    end
  end

  // ------------------------------------------------------------
  // working register byte load and widen
  // ------------------------------------------------------------
  always_comb begin
    unique case (widenOp)
      msau_pkg::MSAU_WID_SIGN:
        workingRegNew = {{8{workingRegOld[7]}}, workingRegOld[7:0]};
      msau_pkg::MSAU_WID_ZERO: workingRegNew = {8'h00, workingRegOld[7:0]};
      default: workingRegNew = {workingRegOld[15:8], readData_reg[7:0]};
    endcase
  end

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  pcEven_a: assert property (@(posedge clk) disable iff (!rst_b)
    configReady && pcAdvance && !pcLoad && !vectorTake && !pcBackward
    |=> programCounter_reg == $past(programCounter_reg) + 24'h000002)
    else $error("program counter did not step by two");
  resetFetch_a: assert property (@(posedge clk)
    $rose(rst_b) |-> programCounter_reg == 24'h000000)
    else $error("fetch does not start at zero");
  vectorArea_a: assert property (@(posedge clk) disable iff (!rst_b)
    configReady && vectorTake |=> programCounter_reg < msau_pkg::USER_CODE_LO)
    else $error("vector outside reserved area");
  misWrite_a: assert property (@(posedge clk) disable iff (!rst_b)
    writeReq.valid && !writeReq.isByte && writeAddress[0]
    |-> memWriteLane == 2'h0 ##1 addressErrorTrap_reg)
    else $error("misaligned write reached memory or no trap");
  byteLane_a: assert property (@(posedge clk) disable iff (!rst_b)
    writeReq.valid && writeReq.isByte && memWriteLane != 2'h0
    |-> memWriteLane == (writeAddress[0] ? 2'h2 : 2'h1))
    else $error("wrong byte lane strobed");
  zeroRead_a: assert property (@(posedge clk) disable iff (!rst_b)
    readReq.valid && !readPsv && readAddress > msau_pkg::DATA_IMPL_TOP
    |=> readData_reg == 16'h0000)
    else $error("outside read not zero");
  byteRead_a: assert property (@(posedge clk) disable iff (!rst_b)
    readReq.valid && readReq.isByte && !readOutside
    |=> readData_reg[15:8] == 8'h00)
    else $error("byte read not on low lane");
  misRead_a: assert property (@(posedge clk) disable iff (!rst_b)
    readReq.valid && !readReq.isByte && readAddress[0] |=> addressErrorTrap_reg)
    else $error("misaligned read gave no trap");
  postInc_a: assert property (@(posedge clk) disable iff (!rst_b)
    readReq.mode == msau_pkg::MSAU_AM_POSTINC
    |-> readPointerNext == readReq.pointer + (readReq.isByte ? 16'h0001 : 16'h0002))
    else $error("post increment not scaled");
  byteLoad_a: assert property (@(posedge clk) disable iff (!rst_b)
    widenOp == msau_pkg::MSAU_WID_NONE |-> workingRegNew[15:8] == workingRegOld[15:8])
    else $error("byte load touched high byte");
  pcLoadEven_a: assert property (@(posedge clk) disable iff (!rst_b)
    configReady && pcLoad && !vectorTake |=> programCounter_reg[0] == 1'b0)
    else $error("loaded program counter is odd");
  pcBack_a: assert property (@(posedge clk) disable iff (!rst_b)
    configReady && pcAdvance && pcBackward && !pcLoad && !vectorTake
    |=> programCounter_reg == $past(programCounter_reg) - 24'h000002)
    else $error("program counter did not step back by two");
  noEarlyFetch_a: assert property (@(posedge clk) disable iff (!rst_b)
    !configReady |=> $stable(programCounter_reg))
    else $error("program counter moved before config load");
  outsideWrite_a: assert property (@(posedge clk) disable iff (!rst_b)
    writeReq.valid && writeAddress > msau_pkg::DATA_IMPL_TOP |-> memWriteLane == 2'h0)
    else $error("write outside implemented memory strobed");
  psvWrite_a: assert property (@(posedge clk) disable iff (!rst_b)
    writeReq.valid && writePsv |-> memWriteLane == 2'h0)
    else $error("write into visibility window strobed");
  sfrZero_a: assert property (@(posedge clk) disable iff (!rst_b)
    readReq.valid && readAddress <= msau_pkg::SFR_TOP && !sfrImplemented
    |=> readData_reg == 16'h0000)
    else $error("unimplemented function register read not zero");
  wordLanes_a: assert property (@(posedge clk) disable iff (!rst_b)
    writeReq.valid && !writeReq.isByte && !writeAddress[0]
    && writeAddress <= msau_pkg::DATA_IMPL_TOP |-> memWriteLane == 2'h3)
    else $error("aligned word write missed a lane");
  cfgHold_a: assert property (@(posedge clk) disable iff (!rst_b)
    configReady |=> configReady)
    else $error("config ready dropped");
  signWiden_a: assert property (@(posedge clk) disable iff (!rst_b)
    widenOp == msau_pkg::MSAU_WID_SIGN |-> workingRegNew[15:8] == {8{workingRegOld[7]}})
    else $error("sign widen wrong");
  nearField_a: assert property (@(posedge clk) disable iff (!rst_b)
    readReq.mode == msau_pkg::MSAU_AM_NEAR |-> readAddress <= msau_pkg::NEAR_TOP)
    else $error("near address beyond near space");
endmodule : msau_top

/* File: rtl/msau_pkg.sv */
// memory space access unit package: address map, field layout, carriers
// assumes a 16-bit core with 24-bit program space and 16-bit byte data space
package msau_pkg;
  // program space
  localparam logic [23:0] PROG_RESET_ADDR = 24'h000000;
  localparam logic [23:0] PROG_START_WORD = 24'h000002;
  localparam logic [23:0] IVT_PRI_LO = 24'h000004;
  localparam logic [23:0] IVT_PRI_HI = 24'h0000ff;
  localparam logic [23:0] IVT_ALT_LO = 24'h000100;
  localparam logic [23:0] IVT_ALT_HI = 24'h0001ff;
  localparam logic [23:0] USER_CODE_LO = 24'h000200;
  localparam logic [23:0] USER_SPACE_HI = 24'h7fffff;
  localparam logic [23:0] CFG_BASE_SMALL = 24'h0057f8;
  localparam logic [23:0] CFG_BASE_LARGE = 24'h00abf8;
  localparam logic [23:0] PC_STEP = 24'h000002;
  localparam int CFG_WORDS = 4;
  localparam int TBL_PAGE_CFG_BIT = 7;
  // data space
  localparam logic [15:0] DATA_IMPL_TOP = 16'h3fff;
  localparam logic [15:0] SFR_TOP = 16'h07ff;
  localparam logic [15:0] NEAR_TOP = 16'h1fff;
  localparam int EA_PSV_BIT = 15;
  localparam int NEAR_FIELD_W = 13;
  localparam logic [15:0] STEP_BYTE = 16'h0001;
  localparam logic [15:0] STEP_WORD = 16'h0002;

  typedef enum logic [1:0] {MSAU_AM_INDIRECT, MSAU_AM_POSTINC, MSAU_AM_NEAR, MSAU_AM_MOVDIR}
    msau_mode_t;
  typedef enum logic [1:0] {MSAU_WID_NONE, MSAU_WID_SIGN, MSAU_WID_ZERO} msau_widen_t;

  typedef struct packed {
    logic valid;
    logic isByte;
    msau_mode_t mode;
    logic [15:0] pointer;
    logic [15:0] directField;
  } msau_req_t;
endpackage : msau_pkg

/* File: rtl/msau_addr_gen.sv */
// one data space address generator; used twice, once for reads, once for writes
// assumes requests are synchronous to clk and held for one cycle
`timescale 1ns/1ps
module msau_addr_gen (
  input wire logic clk,
  input wire logic rst_b,
  input wire msau_pkg::msau_req_t req,
  output logic [15:0] effectiveByteAddress,
  output logic [15:0] pointerNext,
  output logic misaligned,
  output logic psvSelect,
  output logic [15:0] lastAddress_reg
);
  logic [15:0] stepSize;

  always_comb begin
    unique case (req.mode)
      msau_pkg::MSAU_AM_NEAR:
        effectiveByteAddress = {3'h0, req.directField[msau_pkg::NEAR_FIELD_W-1:0]};
      msau_pkg::MSAU_AM_MOVDIR: effectiveByteAddress = req.directField;
      default: effectiveByteAddress = req.pointer;
    endcase
  end

  // post-increment is scaled by access size
  assign stepSize = req.isByte ? msau_pkg::STEP_BYTE : msau_pkg::STEP_WORD;
  assign pointerNext = (req.mode == msau_pkg::MSAU_AM_POSTINC) ?
    req.pointer + stepSize : req.pointer;
  // only word accesses can be misaligned
  assign misaligned = req.valid && !req.isByte && effectiveByteAddress[0];
  assign psvSelect = effectiveByteAddress[msau_pkg::EA_PSV_BIT];

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      lastAddress_reg <= 16'h0000;
    end else if (req.valid) begin
      lastAddress_reg <= effectiveByteAddress;
    end
  end
endmodule : msau_addr_gen

/* File: rtl/msau_cfg_loader.sv */
// copies the reserved configuration words into configuration registers after reset
// assumes a one-cycle program memory read port shared with the fetch path
`timescale 1ns/1ps
module msau_cfg_loader #(
  parameter logic [23:0] CFG_BASE = msau_pkg::CFG_BASE_LARGE
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [15:0] progReadData,
  output logic cfgReadReq,
  output logic [23:0] cfgReadAddr,
  output logic [63:0] cfgRegs_reg,
  output logic cfgDone
);
  typedef enum logic [1:0] {MSAU_CL_ISSUE, MSAU_CL_CAPTURE, MSAU_CL_DONE} msau_cl_state_t;
  msau_cl_state_t state_reg;
  logic [1:0] index_reg;
  logic [63:0] packed_reg;

  // address held through capture so the port still shows the config word being taken
  assign cfgReadReq = (state_reg != MSAU_CL_DONE);
  assign cfgReadAddr = CFG_BASE + {21'h0, index_reg, 1'b0};
  assign cfgDone = (state_reg == MSAU_CL_DONE);

  // the packed flash order differs from register order: reverse bits in each word
  function automatic logic [63:0] remap(input logic [63:0] p);
    logic [63:0] r;
    r = 64'h0;
    for (int w = 0; w < 4; w++) begin
      for (int b = 0; b < 16; b++) begin
        r[w*16 + b] = p[w*16 + 15 - b];
      end
    end
    return r;
  endfunction : remap

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state_reg <= MSAU_CL_ISSUE;
      index_reg <= 2'h0;
      packed_reg <= 64'h0;
    end else begin
      unique case (state_reg)
        MSAU_CL_ISSUE: state_reg <= MSAU_CL_CAPTURE;
        MSAU_CL_CAPTURE: begin
          packed_reg[index_reg*16 +: 16] <= progReadData;
          index_reg <= index_reg + 2'h1;
          state_reg <= (index_reg == 2'h3) ? MSAU_CL_DONE : MSAU_CL_ISSUE;
        end
        MSAU_CL_DONE: state_reg <= MSAU_CL_DONE;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cfgRegs_reg <= 64'h0;
    end else if (state_reg == MSAU_CL_CAPTURE && index_reg == 2'h3) begin
      cfgRegs_reg <= remap({progReadData, packed_reg[47:0]});
    end
  end

  cfgLoadLen_a: assert property (@(posedge clk) disable iff (!rst_b)
    $rose(cfgDone) |-> $past(state_reg, 1) == MSAU_CL_CAPTURE)
    else $error("config copy ended without final capture");
endmodule : msau_cfg_loader

/* File: dv/msau_mem_model.sv */
// far-side model: program memory and data memory array behind the unit
// assumes one-cycle word reads and lane-strobed writes on the rising clock edge
`timescale 1ns/1ps
module msau_mem_model (
  input wire logic clk,
  input wire logic [23:0] progAddr,
  output logic [23:0] progWordData,
  input wire logic [14:0] memReadWordAddr,
  input wire logic [14:0] memWriteWordAddr,
  input wire logic [1:0] memWriteLane,
  input wire logic [15:0] memWriteData,
  output logic [15:0] memReadWord,
  output logic sfrImplemented
);
  // ----------------------------------------
  // storage
  // ----------------------------------------
  logic [15:0] mem [0:8191];

  initial begin
    for (int i = 0; i < 8192; i++) begin
      mem[i] = 16'(i) ^ 16'h5aa5;
    end
  end

  // the image keeps a jump at the reset address; other words follow a pattern
  always_comb begin
    if (progAddr == 24'h000000) begin
      progWordData = 24'h040000;
    end else begin
      progWordData = {progAddr[7:0], progAddr[15:0] ^ 16'hc3a5};
    end
  end

  // aliased index on purpose: out-of-range reads still show data, so zeroing is visible
  assign memReadWord = mem[memReadWordAddr[12:0]];
  // only the first 128 bytes of function register space hold registers
  assign sfrImplemented = (memReadWordAddr < 15'h0040);

  always @(posedge clk) begin
    if (memWriteLane[0]) begin
      mem[memWriteWordAddr[12:0]][7:0] <= memWriteData[7:0];
    end
    if (memWriteLane[1]) begin
      mem[memWriteWordAddr[12:0]][15:8] <= memWriteData[15:8];
    end
  end
endmodule : msau_mem_model

/* File: dv/memory_space_access_unit_tb.sv */
// testbench for the memory space access unit: drives the cpu side, checks ports
// assumes msau_mem_model stands in for program and data memory
`timescale 1ns/1ps
module memory_space_access_unit_tb;
  logic clk, rst_b, pcAdvance, pcBackward, pcLoad, vectorTake, vectorAlternate;
  logic [23:0] pcLoadValue, programCounter_reg, progWordData, progAddr, fetchWord_reg;
  logic [6:0] vectorIndex;
  logic programFetchValid, progUnimplemented, tableAccessDenied, psvRead, sfrImplemented;
  msau_pkg::msau_req_t readReq, writeReq;
  logic [15:0] writeData, readPointerNext, writePointerNext, memReadWord, memWriteData;
  logic [15:0] readData_reg, workingRegOld, workingRegNew;
  logic [14:0] memReadWordAddr, memWriteWordAddr;
  logic [1:0] memWriteLane;
  msau_pkg::msau_widen_t widenOp;
  logic addressErrorTrap_reg, configReady;
  logic [63:0] configRegs;
  int failures = 0;
  int checks_done = 0;
  int cycles = 0;

  msau_top dut_u (.clk(clk), .rst_b(rst_b), .pcAdvance(pcAdvance), .pcBackward(pcBackward),
    .pcLoad(pcLoad), .pcLoadValue(pcLoadValue), .vectorTake(vectorTake),
    .vectorAlternate(vectorAlternate), .vectorIndex(vectorIndex),
    .programCounter_reg(programCounter_reg), .programFetchValid(programFetchValid),
    .progWordData(progWordData), .progAddr(progAddr), .fetchWord_reg(fetchWord_reg),
    .progUnimplemented(progUnimplemented), .tableRead(1'b0), .tablePageRegister(8'h00),
    .tableOffset(16'h0000), .tableAccessDenied(tableAccessDenied), .readReq(readReq),
    .writeReq(writeReq), .writeData(writeData), .readPointerNext(readPointerNext),
    .writePointerNext(writePointerNext), .memReadWord(memReadWord),
    .sfrImplemented(sfrImplemented), .memReadWordAddr(memReadWordAddr),
    .memWriteWordAddr(memWriteWordAddr), .memWriteLane(memWriteLane),
    .memWriteData(memWriteData), .psvRead(psvRead), .readData_reg(readData_reg),
    .workingRegOld(workingRegOld), .widenOp(widenOp), .workingRegNew(workingRegNew),
    .addressErrorTrap_reg(addressErrorTrap_reg), .configRegs(configRegs),
    .configReady(configReady));

  msau_mem_model mem_u (.clk(clk), .progAddr(progAddr), .progWordData(progWordData),
    .memReadWordAddr(memReadWordAddr), .memWriteWordAddr(memWriteWordAddr),
    .memWriteLane(memWriteLane), .memWriteData(memWriteData), .memReadWord(memReadWord),
    .sfrImplemented(sfrImplemented));

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic chk(input string nm, input logic [63:0] seen, input logic [63:0] exp);
    checks_done++;
    if (seen !== exp) begin
      failures++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task automatic summarize();
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : summarize

  task automatic cyc();
    @(posedge clk);
    #1;
  endtask : cyc

  function automatic msau_pkg::msau_req_t rq(input logic b, input msau_pkg::msau_mode_t m,
      input logic [15:0] p, input logic [15:0] d);
    rq = '{1'b1, b, m, p, d};
  endfunction : rq

  function automatic logic [15:0] mi(input logic [15:0] w);
    mi = w ^ 16'h5aa5;
  endfunction : mi

  // one read: word index this cycle, data one edge later
  task automatic rd(input msau_pkg::msau_req_t r, input logic [14:0] wa,
      input logic [15:0] d, input logic psv);
    readReq = r;
    #1;
    chk("readWordAddr", memReadWordAddr, wa);
    chk("psvRead", psvRead, psv);
    cyc();
    readReq = '0;
    if (!psv) chk("readData", readData_reg, d);
    cyc();
  endtask : rd

  task automatic wr(input msau_pkg::msau_req_t r, input logic [15:0] d, input logic [1:0] ln,
      input logic trap);
    writeReq = r;
    writeData = d;
    #1;
    chk("writeLane", memWriteLane, ln);
    cyc();
    writeReq = '0;
    chk("trap", addressErrorTrap_reg, trap);
    cyc();
  endtask : wr

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_cfg();
    logic [15:0] w, r;
    for (int i = 0; i < 20 && configReady !== 1'b1; i++) cyc();
    chk("configReady", configReady, 1'b1);
    for (int i = 0; i < 4; i++) begin
      w = 16'(msau_pkg::CFG_BASE_LARGE + 24'(2 * i)) ^ 16'hc3a5;
      for (int b = 0; b < 16; b++) r[b] = w[15 - b];
      chk("configWord", configRegs[16 * i +: 16], r);
    end
    chk("resetPc", programCounter_reg, 24'h000000);
  endtask : t_cfg

  task automatic t_pc();
    pcAdvance = 1'b1;
    cyc();
    pcAdvance = 1'b0;
    chk("pcStep", programCounter_reg, 24'h000002);
    pcLoad = 1'b1;
    pcLoadValue = 24'h000200;
    cyc();
    pcLoad = 1'b0;
    pcBackward = 1'b1;
    pcAdvance = 1'b1;
    cyc();
    pcBackward = 1'b0;
    pcAdvance = 1'b0;
    chk("pcBack", programCounter_reg, 24'h0001fe);
    vectorTake = 1'b1;
    vectorIndex = 7'h03;
    cyc();
    chk("vectorPc", programCounter_reg, msau_pkg::IVT_PRI_LO + 24'h000006);
    vectorAlternate = 1'b1;
    vectorIndex = 7'h01;
    cyc();
    vectorTake = 1'b0;
    vectorAlternate = 1'b0;
    chk("altVectorPc", programCounter_reg, msau_pkg::IVT_ALT_LO + 24'h000002);
    pcLoad = 1'b1;
    pcLoadValue = 24'h00ac00;
    cyc();
    pcLoad = 1'b0;
    chk("progUnimpl", progUnimplemented, 1'b1);
    cyc();
    chk("fetchWord", fetchWord_reg, 24'h000000);
  endtask : t_pc

  task automatic t_rd();
    rd(rq(1'b0, msau_pkg::MSAU_AM_INDIRECT, 16'h0010, 16'h0), 15'h0008, mi(16'h8), 1'b0);
    rd(rq(1'b1, msau_pkg::MSAU_AM_INDIRECT, 16'h0011, 16'h0), 15'h0008,
      mi(16'h8) >> 8, 1'b0);
    rd(rq(1'b1, msau_pkg::MSAU_AM_INDIRECT, 16'h0010, 16'h0), 15'h0008,
      mi(16'h8) & 16'h00ff, 1'b0);
    rd(rq(1'b0, msau_pkg::MSAU_AM_INDIRECT, 16'h4000, 16'h0), 15'h2000, 16'h0, 1'b0);
    rd(rq(1'b0, msau_pkg::MSAU_AM_INDIRECT, 16'h0500, 16'h0), 15'h0280, 16'h0, 1'b0);
    rd(rq(1'b0, msau_pkg::MSAU_AM_INDIRECT, 16'h8000, 16'h0), 15'h4000, 16'h0, 1'b1);
    rd(rq(1'b0, msau_pkg::MSAU_AM_NEAR, 16'h0, 16'hfffe), 15'h0fff, mi(16'h0fff), 1'b0);
    rd(rq(1'b0, msau_pkg::MSAU_AM_MOVDIR, 16'h0, 16'h3ffe), 15'h1fff, mi(16'h1fff), 1'b0);
  endtask : t_rd

  task automatic t_wr();
    wr(rq(1'b1, msau_pkg::MSAU_AM_INDIRECT, 16'h0021, 16'h0), 16'h00ab, 2'b10, 1'b0);
    rd(rq(1'b0, msau_pkg::MSAU_AM_INDIRECT, 16'h0020, 16'h0), 15'h0010,
      16'hab00 | (mi(16'h10) & 16'h00ff), 1'b0);
    wr(rq(1'b0, msau_pkg::MSAU_AM_INDIRECT, 16'h0030, 16'h0), 16'h1234, 2'b11, 1'b0);
    wr(rq(1'b0, msau_pkg::MSAU_AM_INDIRECT, 16'h0033, 16'h0), 16'hbeef, 2'b00, 1'b1);
    chk("trapPulse", addressErrorTrap_reg, 1'b0);
    rd(rq(1'b0, msau_pkg::MSAU_AM_INDIRECT, 16'h0032, 16'h0), 15'h0019, mi(16'h19), 1'b0);
    wr(rq(1'b0, msau_pkg::MSAU_AM_INDIRECT, 16'h4000, 16'h0), 16'h5555, 2'b00, 1'b0);
  endtask : t_wr

  task automatic t_gen();
    readReq = rq(1'b1, msau_pkg::MSAU_AM_POSTINC, 16'h0040, 16'h0);
    writeReq = rq(1'b0, msau_pkg::MSAU_AM_POSTINC, 16'h0050, 16'h0);
    writeData = 16'h0000;
    #1;
    chk("rdPtrNext", readPointerNext, 16'h0041);
    chk("wrPtrNext", writePointerNext, 16'h0052);
    cyc();
    readReq = '0;
    writeReq = '0;
    workingRegOld = 16'h12f0;
    widenOp = msau_pkg::MSAU_WID_SIGN;
    #1;
    chk("signWiden", workingRegNew, 16'hfff0);
    widenOp = msau_pkg::MSAU_WID_ZERO;
    #1;
    chk("zeroWiden", workingRegNew, 16'h00f0);
    widenOp = msau_pkg::MSAU_WID_NONE;
    #1;
    chk("byteLoad", workingRegNew, 16'h1285);
    cyc();
  endtask : t_gen

  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      failures++;
      summarize();
    end
  end

  initial begin
    rst_b = 1'b0;
    {pcAdvance, pcBackward, pcLoad, vectorTake, vectorAlternate} = 5'h00;
    pcLoadValue = 24'h000000;
    vectorIndex = 7'h00;
    readReq = '0;
    writeReq = '0;
    writeData = 16'h0000;
    workingRegOld = 16'h0000;
    widenOp = msau_pkg::MSAU_WID_NONE;
    repeat (6) @(posedge clk);
    #1;
    rst_b = 1'b1;
    t_cfg();
    t_pc();
    t_rd();
    t_wr();
    t_gen();
    summarize();
  end
endmodule : memory_space_access_unit_tb
